/* design/crt_timer_defs.vh */
// Function
// [RULE1] chain clocked by bus clock divided by four
// [RULE2] fifteen divider stages in one chain
// [RULE3] first eight stages readable counter at 09
// [RULE4] overflow from counter top, every 1024 clocks
// [RULE5] four stages more give divide by 16384
// [RULE6] three periodic stages, one of four taps
// [RULE7] selected tap divided by eight for watchdog
// [RULE8] rate, enables and flags in register 08
// [RULE9] overflow flag set on wrap FF to 00
// [RULE10] write zero clears flag; reset clears flag, enable
// [RULE11] overflow enable plus flag raises interrupt
// [RULE12] power-on clears chain, cleared again at release
// [RULE13] external reset clears the whole chain
// [RULE14] rate bits pick 2^14..2^17, reset slowest
// [RULE15] periodic flag set on tap, cleared writing zero
// [RULE16] zero to bit 0 of 1FF0 clears watchdog stage
// [RULE17] watchdog timeout raises internal reset
// [RULE18] counter read leaves chain undisturbed
`ifndef CRT_TIMER_DEFS_VH
`define CRT_TIMER_DEFS_VH
`define CRT_ADDR_W         16
`define CRT_ADDR_CTRL      16'h0008
`define CRT_ADDR_COUNT     16'h0009
`define CRT_ADDR_WDOG      16'h1FF0
`define CRT_ADDR_IRQ_STAT  16'h0010
`define CRT_ADDR_IRQ_MASK  16'h0011
`define CRT_BIT_OVF_FLAG   7
`define CRT_BIT_PER_FLAG   6
`define CRT_BIT_OVF_EN     5
`define CRT_BIT_PER_EN     4
`define CRT_BIT_RATE_HI    1
`define CRT_BIT_RATE_LO    0
`define CRT_BIT_WDOG_CLR   0
`define CRT_RATE_RESET     2'h3
`define CRT_PRESCALE_DIV   4
`define CRT_CHAIN_W        15
`define CRT_WDOG_DIV       8
`define CRT_IRQ_OVF        0
`define CRT_IRQ_PER        1
`define CRT_IRQ_WDOG       2
`define CRT_POR_HOLD_CYCLES 32
`endif

/* design/crt_stage_chain.v */
`timescale 1ns/1ps
`include "crt_timer_defs.vh"
// synchronous equivalent of the ripple chain: prescaler plus fifteen stages
module crt_stage_chain (
	input  wire                    clk_sys,
	input  wire                    clear,
	output reg  [1:0]              prescale_reg,
	output reg  [`CRT_CHAIN_W-1:0] chain_reg,
	output wire                    stage_tick
);
	// stage_tick: the chain advances on this cycle
	assign stage_tick = (prescale_reg == 2'h3);

	// prescaler divides the bus clock by four ahead of the first stage
	always @(posedge clk_sys)
	begin
		if (clear)
		begin
			prescale_reg <= 2'h0;
			chain_reg    <= {`CRT_CHAIN_W{1'b0}};
		end
		else
		begin
			prescale_reg <= prescale_reg + 2'h1; // see [RULE1]
			if (stage_tick)
				chain_reg <= chain_reg + {{(`CRT_CHAIN_W-1){1'b0}}, 1'b1}; // see [RULE2]
		end
	end
endmodule // crt_stage_chain

/* design/crt_core_timer.v */
`timescale 1ns/1ps
`include "crt_timer_defs.vh"
module crt_core_timer (
	input  wire                   clk_sys,
	input  wire                   rst,
	input  wire [`CRT_ADDR_W-1:0] bus_addr,
	input  wire [7:0]             bus_wdata,
	input  wire                   bus_wr,
	input  wire                   bus_rd,
	output reg  [7:0]             bus_rdata,
	output reg                    overflow_irq,
	output reg                    periodic_irq,
	output reg                    irq,
	output reg                    watchdog_timeout,
	output reg                    internal_reset,
	output reg                    chain_running
);
	wire [1:0]              prescale;
	wire [`CRT_CHAIN_W-1:0] chain;
	wire                    tick;
	reg                     chain_clear;
	reg  [5:0]              por_cnt_reg;
	reg                     por_done_reg;
	reg                     ovf_flag_reg;
	reg                     per_flag_reg;
	reg                     ovf_en_reg;
	reg                     per_en_reg;
	reg  [1:0]              rate_reg;
	reg  [2:0]              wdog_reg;
	reg  [2:0]              stat_reg;
	reg  [2:0]              mask_reg;
	reg                     wdog_fire_reg;
	wire                    ovf_event;
	wire                    per_event;
	wire                    wdog_event;
	wire                    wr_ctrl;
	wire                    wr_wdog;
	wire                    wr_stat;
	wire                    wr_mask;
	wire [7:0]              ctrl_view;

	// length of the power-on hold in bus clocks
	localparam [5:0] POR_HOLD = `CRT_POR_HOLD_CYCLES;

	// tap of the chain output that is about to rise on this tick
	function rises;
		input [`CRT_CHAIN_W-1:0] cnt;
		input [3:0]              bitn;
		begin
			rises = ((cnt & ((15'h0001 << bitn) - 15'h0001)) ==
				((15'h0001 << bitn) - 15'h0001)) && !cnt[bitn];
		end
	endfunction

	// chain cleared by power-on hold, its release, external and watchdog reset
	always @*
	begin
		chain_clear = rst || !por_done_reg || wdog_fire_reg; // see [RULE12] see [RULE13]
	end

	crt_stage_chain u_chain (
		.clk_sys      (clk_sys),
		.clear        (chain_clear),
		.prescale_reg (prescale),
		.chain_reg    (chain),
		.stage_tick   (tick)
	);

	// counter wraps FF to 00 when low eight stages are all ones
	assign ovf_event  = tick && (chain[7:0] == 8'hFF) && !chain_clear; // see [RULE4] see [RULE9]
	// stage 11 is bus/16384; rate selects stage 11+rate out of three more
	assign per_event  = tick && !chain_clear &&
		rises(chain, 4'h0 + {2'h0, rate_reg} + 4'hB); // see [RULE5] see [RULE6] see [RULE14]
	assign wdog_event = per_event && (wdog_reg == 3'h7); // see [RULE7]

	// register write decode
	assign wr_ctrl = bus_wr && (bus_addr == `CRT_ADDR_CTRL);
	assign wr_wdog = bus_wr && (bus_addr == `CRT_ADDR_WDOG) &&
		!bus_wdata[`CRT_BIT_WDOG_CLR]; // see [RULE16]
	assign wr_stat = bus_wr && (bus_addr == `CRT_ADDR_IRQ_STAT);
	assign wr_mask = bus_wr && (bus_addr == `CRT_ADDR_IRQ_MASK);

	assign ctrl_view = {ovf_flag_reg, per_flag_reg, ovf_en_reg, per_en_reg,
		2'h0, rate_reg}; // see [RULE8]

	// power-on hold: chain held clear, then one more clear cycle at release
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			por_cnt_reg  <= 6'h00;
			por_done_reg <= 1'b0;
		end
		else
		begin
			if (por_cnt_reg != POR_HOLD)
				por_cnt_reg <= por_cnt_reg + 6'h01;
			por_done_reg <= (por_cnt_reg == POR_HOLD); // see [RULE12]
		end
	end

	// control and flags; set wins over a clearing write
	always @(posedge clk_sys)
	begin
		if (rst || wdog_fire_reg)
		begin
			ovf_flag_reg <= 1'b0; // see [RULE10]
			per_flag_reg <= 1'b0;
			ovf_en_reg   <= 1'b0;
			per_en_reg   <= 1'b0;
			rate_reg     <= `CRT_RATE_RESET; // see [RULE14]
		end
		else
		begin
			if (ovf_event)
				ovf_flag_reg <= 1'b1; // see [RULE9]
			else if (wr_ctrl && !bus_wdata[`CRT_BIT_OVF_FLAG])
				ovf_flag_reg <= 1'b0; // see [RULE10]
			if (per_event)
				per_flag_reg <= 1'b1; // see [RULE15]
			else if (wr_ctrl && !bus_wdata[`CRT_BIT_PER_FLAG])
				per_flag_reg <= 1'b0; // see [RULE15]
			if (wr_ctrl)
			begin
				ovf_en_reg <= bus_wdata[`CRT_BIT_OVF_EN];
				per_en_reg <= bus_wdata[`CRT_BIT_PER_EN];
				rate_reg   <= bus_wdata[`CRT_BIT_RATE_HI:`CRT_BIT_RATE_LO];
			end
		end
	end

	// watchdog divide-by-eight stage, only this stage cleared by service
	always @(posedge clk_sys)
	begin
		if (chain_clear || wr_wdog)
			wdog_reg <= 3'h0; // see [RULE16]
		else if (per_event)
			wdog_reg <= wdog_reg + 3'h1; // see [RULE7]
		if (rst)
			wdog_fire_reg <= 1'b0;
		else
			wdog_fire_reg <= wdog_event && !wr_wdog; // see [RULE17]
	end

	// sticky event status, write one to clear, set wins
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			stat_reg <= 3'h0;
			mask_reg <= 3'h0;
		end
		else
		begin
			stat_reg <= (stat_reg & ~(wr_stat ? bus_wdata[2:0] : 3'h0)) |
				{wdog_fire_reg, per_event, ovf_event};
			if (wr_mask)
				mask_reg <= bus_wdata[2:0];
		end
	end

	// read data one cycle later; reads have no side effects
	always @(posedge clk_sys)
	begin
		if (rst)
			bus_rdata <= 8'h00;
		else if (!bus_rd)
			bus_rdata <= 8'h00;
		else if (bus_addr == `CRT_ADDR_CTRL)
			bus_rdata <= ctrl_view;
		else if (bus_addr == `CRT_ADDR_COUNT)
			bus_rdata <= chain[7:0]; // see [RULE3] see [RULE18]
		else if (bus_addr == `CRT_ADDR_IRQ_STAT)
			bus_rdata <= {5'h00, stat_reg};
		else if (bus_addr == `CRT_ADDR_IRQ_MASK)
			bus_rdata <= {5'h00, mask_reg};
		else
			bus_rdata <= 8'h00;
	end

	// registered outputs
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			overflow_irq     <= 1'b0;
			periodic_irq     <= 1'b0;
			irq              <= 1'b0;
			watchdog_timeout <= 1'b0;
			internal_reset   <= 1'b0;
			chain_running    <= 1'b0;
		end
		else
		begin
			overflow_irq     <= ovf_flag_reg && ovf_en_reg; // see [RULE11]
			periodic_irq     <= per_flag_reg && per_en_reg; // see [RULE15]
			irq              <= |(stat_reg & mask_reg);
			watchdog_timeout <= wdog_fire_reg;
			internal_reset   <= wdog_fire_reg; // see [RULE17]
			chain_running    <= !chain_clear;
		end
	end
endmodule // crt_core_timer

/* bench/crt_core_timer_assertions.sv */
`timescale 1ns/1ps
`include "crt_timer_defs.vh"
module crt_core_timer_assertions (
	input wire		clk_sys,
	input wire		rst,
	input wire [15:0]	bus_addr,
	input wire		bus_wr,
	input wire		bus_rd,
	input wire [7:0]	bus_rdata,
	input wire		overflow_irq,
	input wire		irq,
	input wire		watchdog_timeout,
	input wire		internal_reset,
	input wire		chain_running
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// read port, control layout and watchdog pulse relations
	a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_read_zero: assert property (bus_rd && bus_addr == 16'h0020 |=> !bus_rdata)
		else $error("unmapped read not zero");
	a_ctrl_spare_bits: assert property (bus_rd && bus_addr == `CRT_ADDR_CTRL |=> !bus_rdata[3:2])
		else $error("spare control bits set");
	a_wdog_reset_pair: assert property (watchdog_timeout == internal_reset)
		else $error("timeout and reset differ");
	a_wdog_single_pulse: assert property (watchdog_timeout |=> !watchdog_timeout)
		else $error("timeout pulse too long");
	a_wdog_clears_chain: assert property (watchdog_timeout |-> ##[0:2] !chain_running)
		else $error("chain not cleared on timeout");
	a_ovf_irq_flag: assert property (overflow_irq && bus_rd && bus_addr == `CRT_ADDR_CTRL &&
		!$past(bus_wr) && !watchdog_timeout |=> bus_rdata[7] && bus_rdata[5])
		else $error("overflow irq without flag");
	a_reset_chain_clear: assert property ($fell(rst) |-> !chain_running && !irq)
		else $error("chain running after reset");
	// main scenarios seen
	c_overflow: cover property ($rose(overflow_irq));
	c_irq: cover property ($rose(irq));
	c_timeout: cover property (watchdog_timeout);
endmodule // crt_core_timer_assertions
bind crt_core_timer crt_core_timer_assertions u_chk (.clk_sys, .rst, .bus_addr, .bus_wr,
	.bus_rd, .bus_rdata, .overflow_irq, .irq, .watchdog_timeout, .internal_reset, .chain_running);

/* bench/crt_core_timer_tb_top.sv */
`timescale 1ns/1ps
`include "crt_timer_defs.vh"
module crt_core_timer_tb_top;
	reg		clk_sys = 0, rst = 1, bus_wr = 0, bus_rd = 0;
	reg [15:0]	bus_addr = 0;
	reg [7:0]	bus_wdata = 0, d, e;
	wire [7:0]	bus_rdata;
	wire		overflow_irq, periodic_irq, irq, watchdog_timeout, internal_reset, chain_running;
	wire [3:0]	ev = {chain_running, watchdog_timeout, periodic_irq, overflow_irq};
	integer		n_errors = 0, total_checks = 0, cyc = 0, t, c0;
	crt_core_timer u_dut (.clk_sys, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.overflow_irq, .periodic_irq, .irq, .watchdog_timeout, .internal_reset, .chain_running);
	// clock and free cycle count
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	task chk(input [31:0] g, x);
		total_checks = total_checks + 1;
		if (g !== x)
		begin
			n_errors = n_errors + 1;
			$display("Error t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// one-cycle bus strobes, read data taken in the following cycle
	task wr(input [15:0] a, input [7:0] v);
		@(posedge clk_sys);
		bus_wr <= 1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge clk_sys);
		bus_wr <= 0;
	endtask
	task rd(input [15:0] a, output [7:0] v);
		@(posedge clk_sys);
		bus_rd <= 1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 0;
		@(negedge clk_sys);
		v = bus_rdata;
	endtask
	// bounded wait for one of the event outputs
	task wt(input integer s, n);
		@(negedge clk_sys);
		for (t = 0; t < n && ev[s] !== 1'b1; t = t + 1)
			@(negedge clk_sys);
		chk(t < n, 1);
	endtask
	task t_reset_values;
		rd(`CRT_ADDR_CTRL, d);
		chk(d, 8'h03);
		rd(`CRT_ADDR_IRQ_MASK, d);
		chk(d, 8'h00);
		rd(16'h0020, d);
		chk(d, 8'h00);
	endtask
	task t_count_rate;
		rd(`CRT_ADDR_COUNT, d);
		repeat (14) @(posedge clk_sys);
		rd(`CRT_ADDR_COUNT, e);
		chk(e - d, 8'h04);
	endtask
	task t_overflow;
		wr(`CRT_ADDR_CTRL, 8'h20);
		wt(0, 1100);
		c0 = cyc;
		wr(`CRT_ADDR_CTRL, 8'hA0);
		rd(`CRT_ADDR_CTRL, d);
		chk(d & 8'hA0, 8'hA0);
		rd(`CRT_ADDR_IRQ_STAT, d);
		chk(d[0], 1);
		chk(irq, 0);
		wr(`CRT_ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(negedge clk_sys);
		chk(irq, 1);
		wr(`CRT_ADDR_IRQ_STAT, 8'h01);
		wr(`CRT_ADDR_CTRL, 8'h20);
		repeat (2) @(negedge clk_sys);
		chk({irq, overflow_irq}, 0);
		wt(0, 1100);
		chk(cyc - c0, 1024);
	endtask
	task t_periodic_wdog;
		wr(`CRT_ADDR_CTRL, 8'h10);
		wt(1, 17000);
		c0 = cyc;
		wr(`CRT_ADDR_CTRL, 8'h10);
		repeat (2) @(negedge clk_sys);
		chk(periodic_irq, 0);
		wt(1, 17000);
		chk(cyc - c0, 16384);
		wr(`CRT_ADDR_WDOG, 8'h00);
		c0 = cyc;
		wt(2, 140000);
		chk(cyc - c0 >= 7 * 16384 && cyc - c0 <= 8 * 16384 + 4, 1);
		chk(internal_reset, 1);
		rd(`CRT_ADDR_CTRL, d);
		chk(d, 8'h03);
	endtask
	task t_mid_reset;
		@(posedge clk_sys);
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		rd(`CRT_ADDR_COUNT, d);
		chk(d, 8'h00);
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 0;
		wt(3, 100);
		t_reset_values;
		t_count_rate;
		t_overflow;
		t_periodic_wdog;
		t_mid_reset;
		final_report;
	end
	// hang guard
	initial
	begin
		repeat (250000) @(posedge clk_sys);
		n_errors = n_errors + 1;
		final_report;
	end
endmodule // crt_core_timer_tb_top
